/* File: src/usbec_pkg.sv */
// Constants, types and layouts for the low-speed USB endpoint control block
// What this block does
// - Shared ep1/2 tx-done flag sets when buffer sent and host ACKs.
// - Writing 1 to ep1/2 tx-done clear drops the flag; 0 does nothing.
// - Ep1/2 IN gets NAK while tx arm is 0 or tx-done flag set.
// - End-of-packet flag sets on bus EOP; writing 1 to its clear drops it.
// - Resume flag sets on bus activity while suspended; write 1 clears it.
// - Interrupt request when ep1/2 tx-done flag set and its enable is 1.
// - Interrupt request when end-of-packet flag set and its enable is 1.
// - Ep0 IN data uses DATA1 when ep0 toggle is 1, else DATA0.
// - Ep1/2 IN data uses DATA1 when ep1/2 toggle is 1, else DATA0.
// - Ep0 force stall answers IN/OUT with STALL; a SETUP clears it.
// - Ep0 IN gets NAK while ep0 tx arm is 0 or tx-done set.
// - Ep0 OUT gets NAK while ep0 rx arm is 0 or rx-done set.
// - Ep0 IN sends the byte count held in the ep0 four-bit count.
// - Ep1/2 IN sends the byte count held in the ep1/2 count field.
// - Buffer select picks ep2 (1) or ep1 (0); ep2 IN gets NAK otherwise.
// - Ep2 IN gets data only if done 0, arm 1, stall 0, enable 1.
// - Remote wake bit drives K on the lines; it never sets resume flag.
// - In-before-out flag sets if ep0 tx-done set when rx-done sets.
// - Ep1/ep2 answer IN tokens with data or NAK only while their enable bit is 1; force stall answers even when disabled.
// - Ep1/ep2 force stall answers IN/OUT to that endpoint with STALL.
// - Status shows last ep0 receive toggle and whether last ep0 token was SETUP.
// - Suspend request stops the module and puts it in suspend.
package usbec_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] REG_FLAGS1 = 3'h0;
    localparam logic [2:0] REG_EP0_CTL = 3'h1;
    localparam logic [2:0] REG_EP12_CTL = 3'h2;
    localparam logic [2:0] REG_EP12_ES = 3'h3;
    localparam logic [2:0] REG_EP0_STAT = 3'h4;
    localparam logic [2:0] REG_EP0_FLAGS = 3'h5;
    // usb_event_flags_1 bit positions
    localparam int B_TX12_DONE = 7;
    localparam int B_EOP = 6;
    localparam int B_RESUME = 5;
    localparam int B_RESUME_CLR = 4;
    localparam int B_TX12_IE = 3;
    localparam int B_EOP_IE = 2;
    localparam int B_TX12_CLR = 1;
    localparam int B_EOP_CLR = 0;
    // Control registers: toggle, stall or select, arm, 4-bit count
    localparam int B_TOGGLE = 7;
    localparam int B_EP0_FORCE_STALL = 6;
    localparam int B_SELECT = 6;
    localparam int B_TX_ARM = 5;
    localparam int B_RX_ARM = 4;
    localparam int B_WAKE = 4;
    localparam int B_CNT_HI = 3;
    // ep12_enable_stall_control bit positions
    localparam int B_IBO_CLR = 7;
    localparam int B_IBO = 6;
    localparam int B_EP2_ON = 5;
    localparam int B_EP1_ON = 4;
    localparam int B_EP2_STALL = 3;
    localparam int B_EP1_STALL = 2;
    // ep0_receive_status and ep0 event flag bit positions
    localparam int B_RX_SEQ = 7;
    localparam int B_SETUP = 6;
    localparam int B_TX0_DONE = 7;
    localparam int B_RX0_DONE = 6;
    localparam int B_SUSPEND = 5;
    localparam int B_TX0_CLR = 1;
    localparam int B_RX0_CLR = 0;
    // Endpoint numbers
    localparam logic [1:0] EP0 = 2'h0;
    localparam logic [1:0] EP1 = 2'h1;
    localparam logic [1:0] EP2 = 2'h2;
    // Remote wake hold window kept by software, in ms and clock cycles
    localparam int CLK_HZ = 10000000;
    localparam int WAKE_MIN_MS = 10;
    localparam int WAKE_MAX_MS = 15;
    localparam int WAKE_MIN_CYC = (WAKE_MIN_MS * (CLK_HZ / 1000));
    localparam int WAKE_MAX_CYC = (WAKE_MAX_MS * (CLK_HZ / 1000));
    typedef enum logic [1:0] {
        TOK_OUT = 2'h0,
        TOK_IN = 2'h1,
        TOK_SETUP = 2'h3
    } usbec_tok_t;
    // Gray coded along none, nak, stall, data, ack
    typedef enum logic [2:0] {
        RSP_NONE = 3'h0,
        RSP_NAK = 3'h1,
        RSP_STALL = 3'h3,
        RSP_DATA = 3'h2,
        RSP_ACK = 3'h6
    } usbec_rsp_t;
    // Events from the serial engine, one-cycle pulses
    typedef struct packed {
        logic tok_valid;
        usbec_tok_t tok_kind;
        logic [1:0] tok_ep;
        logic tx_acked;
        logic rx_done;
        logic rx_data1;
        logic eop_seen;
        logic bus_active;
    } usbec_sie_in_t;
    // Decision handed back to the serial engine
    typedef struct packed {
        logic valid;
        usbec_rsp_t kind;
        logic data1;
        logic [3:0] byte_count;
        logic buf_ep2;
    } usbec_rsp_out_t;
    typedef struct packed {
        logic [7:0] rdata;
        usbec_rsp_out_t rsp;
        logic irq;
        logic last_in_ep0;
        logic tx12_done, eop, resume, tx12_ie, eop_ie;
        logic tx0_tog, ep0_force_stall, tx0_arm, rx0_arm;
        logic [3:0] tx0_cnt;
        logic tx12_tog, sel_ep2, tx12_arm, wake;
        logic [3:0] tx12_cnt;
        logic ibo, ep2_on, ep1_on, ep2_stall, ep1_stall;
        logic rx_seq, setup_seen;
        logic tx0_done, rx0_done, suspend;
    } usbec_state_t;
endpackage : usbec_pkg

/* File: src/usbec_endpoint_ctl.sv */
// Endpoint control, status and handshake decision logic
`timescale 1ns/10ps
module usbec_endpoint_ctl (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire usbec_pkg::usbec_sie_in_t sie_i,
    output usbec_pkg::usbec_rsp_out_t rsp_o,
    output logic irq_o,
    output logic k_drive_o,
    output logic suspend_o
);
    usbec_pkg::usbec_state_t st;
    usbec_pkg::usbec_state_t next_st;
    logic [7:0] wd;
    logic wr_f1, wr_c0, wr_c1, wr_es, wr_f0;
    logic tok_live;

    // ---------------------------------------------------------------
    // Register writes and hardware events
    // ---------------------------------------------------------------
    // Hardware sets are applied after software clears so an event in
    // the clearing cycle survives.
    always_comb begin
        next_st = st;
        wd = reg_wdata_i;
        wr_f1 = reg_we_i && reg_addr_i == usbec_pkg::REG_FLAGS1;
        wr_c0 = reg_we_i && reg_addr_i == usbec_pkg::REG_EP0_CTL;
        wr_c1 = reg_we_i && reg_addr_i == usbec_pkg::REG_EP12_CTL;
        wr_es = reg_we_i && reg_addr_i == usbec_pkg::REG_EP12_ES;
        wr_f0 = reg_we_i && reg_addr_i == usbec_pkg::REG_EP0_FLAGS;
        // Suspended module ignores tokens; only bus activity counts
        tok_live = sie_i.tok_valid && !st.suspend;
        next_st.rsp.valid = 1'b0;
        // Software writes
        if (wr_f1) begin
            next_st.tx12_ie = wd[usbec_pkg::B_TX12_IE];
            next_st.eop_ie = wd[usbec_pkg::B_EOP_IE];
            if (wd[usbec_pkg::B_TX12_CLR]) begin
                next_st.tx12_done = 1'b0;
            end
            if (wd[usbec_pkg::B_EOP_CLR]) begin
                next_st.eop = 1'b0;
            end
            if (wd[usbec_pkg::B_RESUME_CLR]) begin
                next_st.resume = 1'b0;
            end
        end
        if (wr_c0) begin
            next_st.tx0_tog = wd[usbec_pkg::B_TOGGLE];
            next_st.ep0_force_stall = wd[usbec_pkg::B_EP0_FORCE_STALL];
            next_st.tx0_arm = wd[usbec_pkg::B_TX_ARM];
            next_st.rx0_arm = wd[usbec_pkg::B_RX_ARM];
            next_st.tx0_cnt = wd[usbec_pkg::B_CNT_HI:0];
        end
        if (wr_c1) begin
            next_st.tx12_tog = wd[usbec_pkg::B_TOGGLE];
            next_st.sel_ep2 = wd[usbec_pkg::B_SELECT];
            next_st.tx12_arm = wd[usbec_pkg::B_TX_ARM];
            next_st.wake = wd[usbec_pkg::B_WAKE];
            next_st.tx12_cnt = wd[usbec_pkg::B_CNT_HI:0];
        end
        if (wr_es) begin
            next_st.ep2_on = wd[usbec_pkg::B_EP2_ON];
            next_st.ep1_on = wd[usbec_pkg::B_EP1_ON];
            next_st.ep2_stall = wd[usbec_pkg::B_EP2_STALL];
            next_st.ep1_stall = wd[usbec_pkg::B_EP1_STALL];
            if (wd[usbec_pkg::B_IBO_CLR]) begin
                next_st.ibo = 1'b0;
            end
        end
        if (wr_f0) begin
            next_st.suspend = wd[usbec_pkg::B_SUSPEND];
            if (wd[usbec_pkg::B_TX0_CLR]) begin
                next_st.tx0_done = 1'b0;
            end
            if (wd[usbec_pkg::B_RX0_CLR]) begin
                next_st.rx0_done = 1'b0;
            end
        end
        // Hardware events; the wake drive never feeds the resume flag
        if (sie_i.eop_seen && !st.suspend) begin
            next_st.eop = 1'b1;
        end
        if (sie_i.bus_active && st.suspend) begin
            next_st.resume = 1'b1;
        end
        if (sie_i.tx_acked && !st.suspend) begin
            if (st.last_in_ep0) begin
                next_st.tx0_done = 1'b1;
            end else begin
                next_st.tx12_done = 1'b1;
            end
        end
        if (sie_i.rx_done && !st.suspend) begin
            next_st.rx0_done = 1'b1;
            next_st.rx_seq = sie_i.rx_data1;
            if (st.tx0_done) begin
                next_st.ibo = 1'b1;
            end
        end
        // Handshake decision per token
        if (tok_live) begin
            next_st.rsp.valid = 1'b1;
            next_st.rsp.kind = usbec_pkg::RSP_NONE;
            next_st.rsp.data1 = 1'b0;
            next_st.rsp.byte_count = '0;
            next_st.rsp.buf_ep2 = st.sel_ep2;
            if (sie_i.tok_kind == usbec_pkg::TOK_IN) begin
                next_st.last_in_ep0 = sie_i.tok_ep == usbec_pkg::EP0;
            end
            unique case (sie_i.tok_ep)
                usbec_pkg::EP0: begin
                    next_st.setup_seen =
                        sie_i.tok_kind == usbec_pkg::TOK_SETUP;
                    if (sie_i.tok_kind == usbec_pkg::TOK_SETUP) begin
                        next_st.ep0_force_stall = 1'b0;
                        next_st.rsp.kind = usbec_pkg::RSP_ACK;
                    end else if (st.ep0_force_stall) begin
                        next_st.rsp.kind = usbec_pkg::RSP_STALL;
                    end else if (sie_i.tok_kind == usbec_pkg::TOK_IN) begin
                        if (!st.tx0_arm || st.tx0_done) begin
                            next_st.rsp.kind = usbec_pkg::RSP_NAK;
                        end else begin
                            next_st.rsp.kind = usbec_pkg::RSP_DATA;
                            next_st.rsp.data1 = st.tx0_tog;
                            next_st.rsp.byte_count = st.tx0_cnt;
                        end
                    end else if (!st.rx0_arm || st.rx0_done) begin
                        next_st.rsp.kind = usbec_pkg::RSP_NAK;
                    end else begin
                        next_st.rsp.kind = usbec_pkg::RSP_ACK;
                    end
                end
                usbec_pkg::EP1, usbec_pkg::EP2: begin
                    if ((sie_i.tok_ep == usbec_pkg::EP1 && st.ep1_stall)
                        || (sie_i.tok_ep == usbec_pkg::EP2
                            && st.ep2_stall)) begin
                        next_st.rsp.kind = usbec_pkg::RSP_STALL;
                    end else if (sie_i.tok_kind != usbec_pkg::TOK_IN) begin
                        next_st.rsp.kind = usbec_pkg::RSP_NONE;
                    end else if ((sie_i.tok_ep == usbec_pkg::EP1
                                  && !st.ep1_on)
                                 || (sie_i.tok_ep == usbec_pkg::EP2
                                     && !st.ep2_on)) begin
                        next_st.rsp.kind = usbec_pkg::RSP_NONE;
                    end else if (!st.tx12_arm || st.tx12_done) begin
                        next_st.rsp.kind = usbec_pkg::RSP_NAK;
                    end else if ((sie_i.tok_ep == usbec_pkg::EP2)
                                 != st.sel_ep2) begin
                        next_st.rsp.kind = usbec_pkg::RSP_NAK;
                    end else begin
                        next_st.rsp.kind = usbec_pkg::RSP_DATA;
                        next_st.rsp.data1 = st.tx12_tog;
                        next_st.rsp.byte_count = st.tx12_cnt;
                    end
                end
                default: begin
                    next_st.rsp.kind = usbec_pkg::RSP_NONE;
                end
            endcase
        end
        // Interrupt is a level so a missed edge cannot lose it
        next_st.irq = (next_st.tx12_done && next_st.tx12_ie)
            || (next_st.eop && next_st.eop_ie)
            || next_st.resume;
        // Read data stands the cycle after the strobe only
        next_st.rdata = '0;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                usbec_pkg::REG_FLAGS1: begin
                    next_st.rdata[usbec_pkg::B_TX12_DONE] = st.tx12_done;
                    next_st.rdata[usbec_pkg::B_EOP] = st.eop;
                    next_st.rdata[usbec_pkg::B_RESUME] = st.resume;
                    next_st.rdata[usbec_pkg::B_TX12_IE] = st.tx12_ie;
                    next_st.rdata[usbec_pkg::B_EOP_IE] = st.eop_ie;
                end
                usbec_pkg::REG_EP0_CTL: begin
                    next_st.rdata = {st.tx0_tog, st.ep0_force_stall, st.tx0_arm,
                                     st.rx0_arm, st.tx0_cnt};
                end
                usbec_pkg::REG_EP12_CTL: begin
                    next_st.rdata = {st.tx12_tog, st.sel_ep2, st.tx12_arm,
                                     st.wake, st.tx12_cnt};
                end
                usbec_pkg::REG_EP12_ES: begin
                    next_st.rdata[usbec_pkg::B_IBO] = st.ibo;
                    next_st.rdata[usbec_pkg::B_EP2_ON] = st.ep2_on;
                    next_st.rdata[usbec_pkg::B_EP1_ON] = st.ep1_on;
                    next_st.rdata[usbec_pkg::B_EP2_STALL] = st.ep2_stall;
                    next_st.rdata[usbec_pkg::B_EP1_STALL] = st.ep1_stall;
                end
                usbec_pkg::REG_EP0_STAT: begin
                    next_st.rdata[usbec_pkg::B_RX_SEQ] = st.rx_seq;
                    next_st.rdata[usbec_pkg::B_SETUP] = st.setup_seen;
                end
                usbec_pkg::REG_EP0_FLAGS: begin
                    next_st.rdata[usbec_pkg::B_TX0_DONE] = st.tx0_done;
                    next_st.rdata[usbec_pkg::B_RX0_DONE] = st.rx0_done;
                    next_st.rdata[usbec_pkg::B_SUSPEND] = st.suspend;
                end
                default: begin
                    next_st.rdata = '0; // Unmapped reads as zero
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // Every field, including reset-cleared enables, starts at zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops
    assign reg_rdata_o = st.rdata;
    assign rsp_o = st.rsp;
    assign irq_o = st.irq;
    assign k_drive_o = st.wake;
    assign suspend_o = st.suspend;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    property p_tx12_set;
        sie_i.tx_acked && !st.suspend && !st.last_in_ep0
            |=> st.tx12_done;
    endproperty
    a_tx12_set: assert property (p_tx12_set)
        else $error("ep12 tx done not set after ack");

    property p_tx12_clr;
        wr_f1 && wd[usbec_pkg::B_TX12_CLR] && !sie_i.tx_acked
            |=> !st.tx12_done;
    endproperty
    a_tx12_clr: assert property (p_tx12_clr)
        else $error("ep12 tx done not cleared");

    property p_ep12_nak;
        tok_live && sie_i.tok_kind == usbec_pkg::TOK_IN
            && sie_i.tok_ep == usbec_pkg::EP1 && st.ep1_on
            && !st.ep1_stall && st.tx12_done
            |=> rsp_o.valid && rsp_o.kind == usbec_pkg::RSP_NAK;
    endproperty
    a_ep12_nak: assert property (p_ep12_nak)
        else $error("ep1 IN not NAKed while done set");

    property p_irq_tx;
        st.tx12_done && st.tx12_ie |-> irq_o;
    endproperty
    a_irq_tx: assert property (p_irq_tx)
        else $error("irq missing for ep12 tx done");

    property p_ep0_data;
        rsp_o.valid && rsp_o.kind == usbec_pkg::RSP_DATA
            && st.last_in_ep0
            |-> rsp_o.data1 == $past(st.tx0_tog)
                && rsp_o.byte_count == $past(st.tx0_cnt);
    endproperty
    a_ep0_data: assert property (p_ep0_data)
        else $error("ep0 data toggle or count wrong");

    property p_setup_unstall;
        tok_live && sie_i.tok_kind == usbec_pkg::TOK_SETUP
            && sie_i.tok_ep == usbec_pkg::EP0 && !wr_c0
            |=> !st.ep0_force_stall ##0 st.setup_seen;
    endproperty
    a_setup_unstall: assert property (p_setup_unstall)
        else $error("setup did not clear ep0 stall");

    property p_ep0_out_nak;
        tok_live && sie_i.tok_kind == usbec_pkg::TOK_OUT
            && sie_i.tok_ep == usbec_pkg::EP0 && !st.ep0_force_stall
            && st.rx0_done
            |=> rsp_o.kind == usbec_pkg::RSP_NAK;
    endproperty
    a_ep0_out_nak: assert property (p_ep0_out_nak)
        else $error("ep0 OUT not NAKed");

    property p_ibo;
        sie_i.rx_done && !st.suspend && st.tx0_done |=> st.ibo;
    endproperty
    a_ibo: assert property (p_ibo)
        else $error("in-before-out flag not set");

    property p_ep2_sel;
        tok_live && sie_i.tok_kind == usbec_pkg::TOK_IN
            && sie_i.tok_ep == usbec_pkg::EP2 && !st.sel_ep2
            |=> rsp_o.kind != usbec_pkg::RSP_DATA;
    endproperty
    a_ep2_sel: assert property (p_ep2_sel)
        else $error("ep2 data sent while buffer names ep1");

    property p_wake;
        k_drive_o && !(sie_i.bus_active && st.suspend) && !st.resume
            |=> !st.resume;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake drive set the resume flag");

    property p_eop_set;
        sie_i.eop_seen && !st.suspend |=> st.eop;
    endproperty
    a_eop_set: assert property (p_eop_set)
        else $error("eop flag not set");

    property p_resume_set;
        sie_i.bus_active && st.suspend |=> st.resume;
    endproperty
    a_resume_set: assert property (p_resume_set)
        else $error("resume flag not set");

    property p_ep12_data;
        rsp_o.valid && rsp_o.kind == usbec_pkg::RSP_DATA
            && !st.last_in_ep0
            |-> rsp_o.data1 == $past(st.tx12_tog)
                && rsp_o.byte_count == $past(st.tx12_cnt);
    endproperty
    a_ep12_data: assert property (p_ep12_data)
        else $error("ep12 data fields wrong");

    property p_ep0_in_nak;
        tok_live && sie_i.tok_kind == usbec_pkg::TOK_IN
            && sie_i.tok_ep == usbec_pkg::EP0 && !st.ep0_force_stall
            && !st.tx0_arm
            |=> rsp_o.kind == usbec_pkg::RSP_NAK;
    endproperty
    a_ep0_in_nak: assert property (p_ep0_in_nak)
        else $error("ep0 IN not NAKed");

    property p_ep1_off;
        tok_live && sie_i.tok_ep == usbec_pkg::EP1 && !st.ep1_on
            && !st.ep1_stall
            |=> rsp_o.kind == usbec_pkg::RSP_NONE;
    endproperty
    a_ep1_off: assert property (p_ep1_off)
        else $error("disabled ep1 answered");

    property p_ep2_stall;
        tok_live && sie_i.tok_ep == usbec_pkg::EP2 && st.ep2_stall
            |=> rsp_o.kind == usbec_pkg::RSP_STALL;
    endproperty
    a_ep2_stall: assert property (p_ep2_stall)
        else $error("ep2 not stalled");

    property p_rx_seq;
        sie_i.rx_done && !st.suspend
            |=> st.rx_seq == $past(sie_i.rx_data1);
    endproperty
    a_rx_seq: assert property (p_rx_seq)
        else $error("rx toggle not kept");

    property p_asleep;
        sie_i.tok_valid && st.suspend |=> !rsp_o.valid;
    endproperty
    a_asleep: assert property (p_asleep)
        else $error("token answered in suspend");

    c_ep0_data: cover property (rsp_o.valid
        && rsp_o.kind == usbec_pkg::RSP_DATA && st.last_in_ep0);
    c_ep2_data: cover property (rsp_o.valid
        && rsp_o.kind == usbec_pkg::RSP_DATA && rsp_o.buf_ep2);
    c_resume: cover property (st.suspend ##1 st.resume);
endmodule : usbec_endpoint_ctl

/* File: bench/usbec_host_model.sv */
// Host controller model: tokens and bus events as one-cycle pulses
`timescale 1ns/10ps
module usbec_host_model (
    input wire logic mclk_i,
    output usbec_pkg::usbec_sie_in_t sie_o
);
    // ------------------------------------------------------------
    // Event pulses
    // ------------------------------------------------------------
    // Lines idle until the host speaks
    initial begin
        sie_o = '0;
    end
    // The host may be prompt or idle a few cycles before each event
    task automatic send(input usbec_pkg::usbec_sie_in_t v, input int gap);
        repeat (gap) @(posedge mclk_i);
        @(posedge mclk_i);
        sie_o <= v;
        @(posedge mclk_i);
        sie_o <= '0;
    endtask : send
endmodule : usbec_host_model

/* File: bench/usb_lowspeed_endpoint_control_bench.sv */
// Self-checking bench for the USB endpoint control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module usb_lowspeed_endpoint_control_bench;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] rdata;
    logic irq, kdrv, susp;
    usbec_pkg::usbec_sie_in_t sie;
    usbec_pkg::usbec_rsp_out_t rsp;
    int mismatches = 0;
    int checked = 0;
    int seed = 38;
    // Software's copy of the controls and the flags it expects
    logic [7:0] c0 = 8'h00, c1 = 8'h00, c2 = 8'h00, r;
    logic [1:0] ie = 2'h0, k, ep;
    logic tx0d = 1'b0, rx0d = 1'b0, t12d = 1'b0, eop = 1'b0, res = 1'b0;
    logic ibo = 1'b0, ep0_rx_toggle_seen = 1'b0, stp = 1'b0;
    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    usbec_endpoint_ctl u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .sie_i(sie), .rsp_o(rsp), .irq_o(irq),
        .k_drive_o(kdrv), .suspend_o(susp));
    usbec_host_model u_host (.mclk_i(mclk_i), .sie_o(sie));
    // Register port cycles: one-cycle strobes, read data the cycle after
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge mclk_i);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] m,
            input logic [7:0] e, input string n);
        @(posedge mclk_i);
        addr <= a;
        re <= 1'b1;
        @(posedge mclk_i);
        re <= 1'b0;
        #1 `CHK(n, e, rdata & m)
    endtask : rd
    task automatic ev(input logic [9:0] v);
        u_host.send(v, $random(seed) & 3);
    endtask : ev
    // Event register write; clear bits only drop their flag when 1
    task automatic w0(input logic [7:0] d);
        wr(3'h0, d);
        ie = d[3:2];
        if (d[1]) t12d = 1'b0;
        if (d[0]) eop = 1'b0;
        if (d[4]) res = 1'b0;
    endtask : w0
    task automatic ck();
        repeat (2) @(posedge mclk_i);
        #1 `CHK("irq", (t12d & ie[1]) | (eop & ie[0]) | res, irq)
    endtask : ck
    // Handshake the device owes for a token, from software's copy
    function automatic usbec_pkg::usbec_rsp_t want(input logic [1:0] k,
            input logic [1:0] ep);
        logic e2;
        e2 = (ep == 2'h2);
        if (ep == 2'h0) begin
            if (k == 2'h3) return usbec_pkg::RSP_ACK;
            if (c0[6]) return usbec_pkg::RSP_STALL;
            if (k == 2'h1 && (!c0[5] || tx0d)) return usbec_pkg::RSP_NAK;
            if (k == 2'h1) return usbec_pkg::RSP_DATA;
            if (!c0[4] || rx0d) return usbec_pkg::RSP_NAK;
            return usbec_pkg::RSP_ACK;
        end
        if (ep == 2'h3) return usbec_pkg::RSP_NONE;
        if (c2[e2 ? 3 : 2]) return usbec_pkg::RSP_STALL;
        if (k != 2'h1 || !c2[e2 ? 5 : 4]) return usbec_pkg::RSP_NONE;
        if (!c1[5] || t12d || c1[6] != e2) return usbec_pkg::RSP_NAK;
        return usbec_pkg::RSP_DATA;
    endfunction : want
    // One token, its answer checked, then the host's follow-up
    task automatic tok(input logic [1:0] k, input logic [1:0] ep);
        usbec_pkg::usbec_rsp_t w;
        logic d;
        w = want(k, ep);
        ev({1'b1, k, ep, 5'h00});
        #1 `CHK("valid", 1'b1, rsp.valid)
        `CHK("kind", w, rsp.kind)
        if (ep == 2'h0) stp = (k == 2'h3);
        if (ep == 2'h0 && k == 2'h3) c0[6] = 1'b0;
        if (w == usbec_pkg::RSP_DATA) begin
            `CHK("data1", ep == 2'h0 ? c0[7] : c1[7], rsp.data1)
            `CHK("cnt", ep == 2'h0 ? c0[3:0] : c1[3:0], rsp.byte_count)
            `CHK("buf", c1[6], rsp.buf_ep2)
            ev(10'h010);
            if (ep == 2'h0) tx0d = 1'b1;
            else t12d = 1'b1;
        end else if (w == usbec_pkg::RSP_ACK) begin
            d = $random(seed);
            ev({7'h01, d, 2'h0});
            if (tx0d) ibo = 1'b1;
            rx0d = 1'b1;
            ep0_rx_toggle_seen = d;
        end
    endtask : tok
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // Watchdog: the tests need a few thousand cycles
    initial begin
        repeat (30000) @(posedge mclk_i);
        mismatches++;
        results();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 8'hFF, 8'h00, "reset");
        end
        $display("test reset done");
        ev(10'h002);
        eop = 1'b1;
        w0(8'h04);
        ck();
        rd(3'h0, 8'hFF, 8'h44, "eop kept");
        w0(8'h01);
        ck();
        $display("test eop done");
        c1 = 8'h10;
        wr(3'h2, c1);
        ev(10'h001);
        ck();
        `CHK("kdrive", 1'b1, kdrv)
        rd(3'h0, 8'h20, 8'h00, "no resume");
        c1 = 8'h00;
        // Wake hold kept short; software alone times it
        wr(3'h2, c1);
        wr(3'h5, 8'h20);
        ck();
        `CHK("kdrive off", 1'b0, kdrv)
        `CHK("suspend", 1'b1, susp)
        ev(10'h280);
        #1 `CHK("ignored", 1'b0, rsp.valid)
        ev(10'h001);
        res = 1'b1;
        ck();
        w0(8'h10);
        wr(3'h5, 8'h00);
        ck();
        `CHK("awake", 1'b0, susp)
        $display("test wake and suspend done");
        // Ep2 ready but buffer names ep1, then served, then still done
        c2 = 8'h20;
        wr(3'h3, c2);
        c1 = 8'h25;
        wr(3'h2, c1);
        tok(2'h1, 2'h2);
        c1 = 8'hE5;
        wr(3'h2, c1);
        tok(2'h1, 2'h2);
        w0(8'h08);
        ck();
        tok(2'h1, 2'h2);
        w0(8'h0A);
        ck();
        $display("test shared buffer done");
        for (int i = 0; i < 80; i++) begin
            c0 = $random(seed);
            c1 = $random(seed) & 8'hEF;
            c2 = $random(seed) & 8'hBC;
            wr(3'h1, c0);
            wr(3'h2, c1);
            wr(3'h3, c2);
            if (c2[7]) ibo = 1'b0;
            c2[7] = 1'b0;
            k = $random(seed);
            ep = $random(seed);
            tok((k == 2'h2) ? 2'h3 : k, ep);
            rd(3'h0, 8'hFF, {t12d, eop, res, 1'b0, ie, 2'h0}, "flg");
            rd(3'h1, 8'hFF, c0, "ep0ctl");
            rd(3'h2, 8'hFF, c1, "ep12ctl");
            rd(3'h3, 8'h7C, {1'b0, ibo, c2[5:2], 2'h0}, "es");
            rd(3'h4, 8'hC0, {ep0_rx_toggle_seen, stp, 6'h00}, "stat");
            rd(3'h5, 8'hC0, {tx0d, rx0d, 6'h00}, "ep0flg");
            r = $random(seed);
            wr(3'h5, {6'h00, r[7:6]});
            if (r[6]) rx0d = 1'b0;
            if (r[7]) tx0d = 1'b0;
            w0(r & 8'h0E);
            ck();
        end
        $display("test random traffic done");
        results();
    end
endmodule : usb_lowspeed_endpoint_control_bench
